//--- verilog/er_pkg.sv
`default_nettype none
// ****************************************************************
// event router shared constants and carriers
// ****************************************************************
package er_pkg;

  // input counts: internal control lines and gpio-capable pads
  localparam int ER_NUM_INT  = 8;
  localparam int ER_NUM_PIN  = 8;
  localparam int ER_NUM_IN   = ER_NUM_INT + ER_NUM_PIN;

  // four interrupt targets plus one wake-up target
  localparam int ER_NUM_IRQ  = 4;
  localparam int ER_NUM_OUT  = ER_NUM_IRQ + 1;
  localparam int ER_WAKE_IDX = ER_NUM_IRQ;

  // field position of the pads inside the joined input vector
  localparam int ER_PIN_LSB  = ER_NUM_INT;

  // register clock: 200 MHz
  localparam int ER_CLK_NS   = 5;
  // status readout latency through the synchroniser, in cycles
  localparam int ER_SYNC_CYC = 2;

  typedef logic [ER_NUM_IN-1:0]                  er_vec_t;
  typedef logic [ER_NUM_OUT-1:0][ER_NUM_IN-1:0]  er_map_t;

  // software configuration, all plain ports
  typedef struct packed {
    er_map_t out_mask;    // 1 = input blocked toward that output
    er_vec_t global_mask; // 1 = input blocked toward every output
    er_vec_t pol_high;    // 1 = high level / rising is active
    er_vec_t latch_mode;  // 1 = latched (edge), 0 = direct level
  } er_cfg_t;

  // values after reset
  localparam er_map_t ER_MAP_RST = '0;
  localparam er_vec_t ER_VEC_RST = '0;
  localparam logic [ER_NUM_IRQ-1:0] ER_IRQ_RST = '0;

  // readout state of the router
  typedef struct packed {
    er_map_t                 sync1;
    er_map_t                 sync2;
    er_vec_t                 lsync1;
    er_vec_t                 lsync2;
    logic [ER_NUM_IRQ-1:0]   irq;
  } er_state_t;

endpackage : er_pkg
`default_nettype wire

//--- verilog/er_evt_cell.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// sticky event cell with clockless capture
// ****************************************************************
// set_a sets q at once, with no clock edge needed; clr is sampled
// on the clock and loses against a set that is still present
module er_evt_cell
  import er_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic set_a,
  input  wire logic clr,
  output var  logic q
);

  logic next_q;

  // hold until cleared on a clock edge
  always_comb begin
    next_q = q;
    if (clr) begin
      next_q = 1'b0;
    end
  end

  // asynchronous set loads a constant, like the reset
  always_ff @(posedge clk or negedge rst_n or posedge set_a) begin
    if (!rst_n) begin
      q <= 1'b0;
    end else if (set_a) begin
      q <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

endmodule // er_evt_cell
`default_nettype wire

//--- verilog/er_router.sv
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// [RULE1] There are exactly four interrupt lines toward the interrupt controller.
// [RULE2] There is one wake-up line toward the clock generation unit.
// [RULE3] An output rises when an enabled event is seen on any input routed to it.
// [RULE4] Events come from internal control lines and from every gpio-capable pad.
// [RULE5] Each input may be routed to several outputs, as interrupt or wake source.
// [RULE6] Each input is used either as a direct level or as a latched edge.
// [RULE7] Software picks per input which polarity counts as active.
// [RULE8] A direct event goes away as soon as its input turns inactive.
// [RULE9] A latched event stays until software clears it.
// [RULE10] A global mask per input blocks it toward all outputs at once.
// [RULE11] A mask per input and output blocks it toward one output only.
// [RULE12] Event status is readable separately for every output.
// [RULE13] Detection and latching work with no running clock.
// [RULE14] A routed event can raise a wake-up request out of suspend.
// [RULE15] Pads are watched whether in their own function or in gpio mode.
// [RULE16] The clock generation unit restarts chosen clocks on a wake-up.
// [RULE17] Status reaches the read side through a two-stage synchroniser.
module er_router
  import er_pkg::*;
(
  input  wire logic                  CORE_CLK,
  input  wire logic                  RST_N,
  input  wire logic [ER_NUM_INT-1:0] INT_EVT,
  input  wire logic [ER_NUM_PIN-1:0] GPIO_PAD,
  input  wire er_cfg_t               CFG,
  input  wire er_vec_t               EVT_CLR,
  output var  logic [ER_NUM_IRQ-1:0] IRQ,
  output var  logic                  WAKE,
  output var  er_map_t               STATUS,
  output var  er_vec_t               LATCHED
);

  // ****************************************************************
  // routing decode
  // ****************************************************************

  // events of one output after both masks
  function automatic er_vec_t route_to(input er_vec_t src,
                                       input er_cfg_t cfg,
                                       input int      o);
    route_to = src & ~cfg.global_mask & ~cfg.out_mask[o];
  endfunction

  // ****************************************************************
  // event sources
  // ****************************************************************

  er_vec_t   ev_in;
  er_vec_t   active;
  er_vec_t   set_a;
  er_vec_t   lat_q;
  er_vec_t   src;
  er_map_t   contrib;
  logic      wake_set;
  logic      wake_clr;
  er_state_t st;
  er_state_t next_st;

  // pads are tapped at the pad, ahead of any function mux
  assign ev_in = {GPIO_PAD, INT_EVT}; // [RULE4] [RULE15]

  // polarity: invert low-active inputs so 1 means active
  assign active = ev_in ~^ CFG.pol_high; // [RULE7]

  // latched inputs arm their cell straight from the input level,
  // so capture works while CORE_CLK is stopped
  assign set_a = active & CFG.latch_mode; // [RULE13]

  // ****************************************************************
  // latch cells
  // ****************************************************************

  // a cell in direct mode is held clear, so direct keeps no state
  genvar gi;
  generate
    for (gi = 0; gi < ER_NUM_IN; gi++) begin : g_cell
      er_evt_cell u_cell (
        .clk   (CORE_CLK),
        .rst_n (RST_N),
        .set_a (set_a[gi]),
        .clr   (EVT_CLR[gi] | ~CFG.latch_mode[gi]), // [RULE9] [RULE8]
        .q     (lat_q[gi])
      );
    end
  endgenerate

  // direct level or latched flag per input
  assign src = (CFG.latch_mode & lat_q) |
               (~CFG.latch_mode & active); // [RULE6] [RULE8]

  // ****************************************************************
  // routing to the five targets
  // ****************************************************************

  // one input may reach any number of outputs
  generate
    for (gi = 0; gi < ER_NUM_OUT; gi++) begin : g_route
      assign contrib[gi] = route_to(src, CFG, gi); // [RULE5] [RULE10] [RULE11]
    end
  endgenerate

  // ****************************************************************
  // wake-up line
  // ****************************************************************

  // wake must rise with all clocks off, so its set is asynchronous;
  // it drops only once the synchronised view shows no source left
  assign wake_set = |contrib[ER_WAKE_IDX]; // [RULE14]
  assign wake_clr = ~|st.sync2[ER_WAKE_IDX];

  er_evt_cell u_wake (
    .clk   (CORE_CLK),
    .rst_n (RST_N),
    .set_a (wake_set),
    .clr   (wake_clr),
    .q     (WAKE) // [RULE2]
  );

  // ****************************************************************
  // synchronised readout
  // ****************************************************************

  // first stage feeds only the second; interrupts come from stage 2
  always_comb begin
    next_st        = st;
    next_st.sync1  = contrib;           // [RULE17]
    next_st.sync2  = st.sync1;          // [RULE17]
    next_st.lsync1 = lat_q;
    next_st.lsync2 = st.lsync1;
    for (int o = 0; o < ER_NUM_IRQ; o++) begin
      next_st.irq[o] = |st.sync2[o];    // [RULE1] [RULE3]
    end
  end

  // state register
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      st.sync1  <= ER_MAP_RST;
      st.sync2  <= ER_MAP_RST;
      st.lsync1 <= ER_VEC_RST;
      st.lsync2 <= ER_VEC_RST;
      st.irq    <= ER_IRQ_RST;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state flops
  assign IRQ     = st.irq;     // [RULE1]
  assign STATUS  = st.sync2;   // [RULE12]
  assign LATCHED = st.lsync2;

  // ****************************************************************
  // checks
  // ****************************************************************

  // column of input 0 across all outputs, its masks, and irq sources
  logic [ER_NUM_OUT-1:0] col0;
  logic [ER_NUM_OUT-1:0] mask_col0;
  logic [ER_NUM_IRQ-1:0] irq_any;

  always_comb begin
    for (int o = 0; o < ER_NUM_OUT; o++) begin
      col0[o]      = STATUS[o][0];
      mask_col0[o] = CFG.out_mask[o][0];
    end
    for (int o = 0; o < ER_NUM_IRQ; o++) begin
      irq_any[o] = |STATUS[o];
    end
  end

  // stage 1 event shows on the interrupt two edges later
  property p_irq_latency;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (|st.sync1[0]) |=> ##1 IRQ[0];
  endproperty
  a_irq_latency: assert property (p_irq_latency) // [RULE3]
    else $error("irq0 missed a synchronised event");

  // an interrupt is never raised without status behind it
  property p_irq_has_status;
    @(posedge CORE_CLK) disable iff (!RST_N)
      $rose(IRQ[1]) |-> $past(|STATUS[1]);
  endproperty
  a_irq_has_status: assert property (p_irq_has_status) // [RULE12]
    else $error("irq1 rose with empty status");

  // globally masked input shows on no output
  property p_global_mask;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (CFG.global_mask[0])[*3] |-> (col0 == '0);
  endproperty
  a_global_mask: assert property (p_global_mask) // [RULE10]
    else $error("globally masked input still in status");

  // per-output mask blocks one target only
  property p_out_mask;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (CFG.out_mask[1][0])[*3] |-> !STATUS[1][0];
  endproperty
  a_out_mask: assert property (p_out_mask) // [RULE11]
    else $error("output mask ignored for input 0");

  // a latched flag holds until cleared
  property p_latch_hold;
    @(posedge CORE_CLK) disable iff (!RST_N)
      lat_q[0] && CFG.latch_mode[0] && !EVT_CLR[0] |=> lat_q[0];
  endproperty
  a_latch_hold: assert property (p_latch_hold) // [RULE9]
    else $error("latched flag lost without a clear");

  // a clear takes effect unless the input is active again
  property p_latch_clear;
    @(posedge CORE_CLK) disable iff (!RST_N)
      EVT_CLR[0] && !set_a[0] |=> !lat_q[0] || set_a[0];
  endproperty
  a_latch_clear: assert property (p_latch_clear) // [RULE9]
    else $error("latched flag survived its clear");

  // direct mode keeps nothing stored
  property p_direct_no_store;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (!CFG.latch_mode[0])[*2] |-> !lat_q[0];
  endproperty
  a_direct_no_store: assert property (p_direct_no_store) // [RULE8]
    else $error("direct input left a stored flag");

  // active-high direct input routed to irq0 reaches status
  property p_polarity;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (!CFG.latch_mode[0] && CFG.pol_high[0] && INT_EVT[0] &&
       !CFG.global_mask[0] && !CFG.out_mask[0][0])[*3]
      |-> STATUS[0][0];
  endproperty
  a_polarity: assert property (p_polarity) // [RULE7]
    else $error("active input absent from status");

  // wake falls only when no routed source remains
  property p_wake_fall;
    @(posedge CORE_CLK) disable iff (!RST_N)
      $fell(WAKE) |-> $past(~|st.sync2[ER_WAKE_IDX]);
  endproperty
  a_wake_fall: assert property (p_wake_fall) // [RULE14]
    else $error("wake dropped while a source was pending");

  // stage-1 wake source implies wake was raised
  property p_wake_rise;
    @(posedge CORE_CLK) disable iff (!RST_N)
      $rose(|st.sync1[ER_WAKE_IDX]) |-> WAKE;
  endproperty
  a_wake_rise: assert property (p_wake_rise) // [RULE14]
    else $error("wake not raised for a routed event");

  // wake is up before the first edge that sees its source
  property p_wake_async;
    @(posedge CORE_CLK) disable iff (!RST_N)
      $rose(wake_set) && $past(RST_N) |-> WAKE;
  endproperty
  a_wake_async: assert property (p_wake_async) // [RULE13]
    else $error("wake waited for a clock edge");

  // a clocked capture would miss this: the flag is set between edges
  property p_latch_capture;
    @(posedge CORE_CLK) disable iff (!RST_N)
      $rose(set_a[0]) && $past(RST_N) |-> lat_q[0];
  endproperty
  a_latch_capture: assert property (p_latch_capture) // [RULE13]
    else $error("input 0 flag waited for a clock edge");

  // latched view trails the flags by exactly the two stages
  property p_latched_sync;
    @(posedge CORE_CLK) disable iff (!RST_N)
      LATCHED == $past(lat_q, ER_SYNC_CYC);
  endproperty
  a_latched_sync: assert property (p_latched_sync) // [RULE17]
    else $error("latched view not two stages behind the flags");

  // each interrupt line follows its own status one edge later
  property p_irq_level;
    @(posedge CORE_CLK) disable iff (!RST_N)
      IRQ == $past(irq_any);
  endproperty
  a_irq_level: assert property (p_irq_level) // [RULE1]
    else $error("interrupt lines disagree with their status");

  // one unmasked latched input reaches all five targets
  property p_route_many;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (lat_q[0] && CFG.latch_mode[0] && !CFG.global_mask[0] &&
       (mask_col0 == '0))[*3] |-> (col0 == '1);
  endproperty
  a_route_many: assert property (p_route_many) // [RULE5]
    else $error("unmasked input 0 missing from a target");

  // an active pad shows in status whatever its pad function
  property p_pad_event;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (!CFG.latch_mode[ER_PIN_LSB] && !CFG.global_mask[ER_PIN_LSB] &&
       !CFG.out_mask[1][ER_PIN_LSB] &&
       (GPIO_PAD[0] == CFG.pol_high[ER_PIN_LSB]))[*3]
      |-> STATUS[1][ER_PIN_LSB];
  endproperty
  a_pad_event: assert property (p_pad_event) // [RULE15]
    else $error("active pad 0 absent from status");

  // an inactive direct pad leaves nothing behind in status
  property p_direct_release;
    @(posedge CORE_CLK) disable iff (!RST_N)
      (!CFG.latch_mode[ER_PIN_LSB] &&
       (GPIO_PAD[0] != CFG.pol_high[ER_PIN_LSB]))[*3]
      |-> !STATUS[1][ER_PIN_LSB];
  endproperty
  a_direct_release: assert property (p_direct_release) // [RULE8]
    else $error("inactive direct pad still in status");

endmodule // er_router
`default_nettype wire

//--- bench/er_cgu_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// clock generation unit wake-up model
// ****************************************************************
module er_cgu_model
  import er_pkg::*;
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic wake,
  input  wire logic auto_on,
  output var  logic clk_run
);
  // once woken the clocks stay on; only a reset stops them here,
  // since the software stop path lies outside this bench
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_run <= 1'b0;
    end else if (wake && auto_on) begin
      clk_run <= 1'b1;
    end
  end
endmodule // er_cgu_model
`default_nettype wire

//--- bench/er_router_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module er_router_tb_top
  import er_pkg::*;
;
  // ****************************************************************
  // stimulus and observed signals
  // ****************************************************************
  logic                  core_clk = 1'b0;
  logic                  rst_n;
  logic [ER_NUM_INT-1:0] int_evt;
  logic [ER_NUM_PIN-1:0] gpio_pad;
  er_cfg_t               cfg;
  er_vec_t               evt_clr;
  logic [ER_NUM_IRQ-1:0] irq;
  logic                  wake;
  er_map_t               status;
  er_vec_t               latched;
  logic                  cgu_on;
  logic                  clk_run;
  int                    bad_count;
  int                    comparisons;

  // free-running core clock
  always #(ER_CLK_NS / 2.0) core_clk = ~core_clk;

  er_router u_er_router (
    .CORE_CLK (core_clk),
    .RST_N    (rst_n),
    .INT_EVT  (int_evt),
    .GPIO_PAD (gpio_pad),
    .CFG      (cfg),
    .EVT_CLR  (evt_clr),
    .IRQ      (irq),
    .WAKE     (wake),
    .STATUS   (status),
    .LATCHED  (latched)
  );

  er_cgu_model u_er_cgu_model (
    .clk     (core_clk),
    .rst_n   (rst_n),
    .wake    (wake),
    .auto_on (cgu_on),
    .clk_run (clk_run)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  // inputs move 1 ns after the edge, well clear of sampling
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic chk_lines(input logic [ER_NUM_IRQ-1:0] e_irq,
                           input logic e_wake);
    comparisons++;
    if (irq !== e_irq || wake !== e_wake) begin
      bad_count++;
      $display("FAIL t=%0t lines irq=%b wake=%b", $time, irq, wake);
    end
  endtask

  task automatic chk_bits(input er_vec_t got, input er_vec_t exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("FAIL t=%0t bits got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  // latched input 0: clear while active must lose, later clear wins
  task automatic t_latch();
    cfg.latch_mode[0] = 1'b1;
    step(1);
    int_evt[0] = 1'b1;
    #1;
    chk_lines(4'h0, 1'b1);
    chk_bits(latched, 16'h0000);
    step(1);
    evt_clr[0] = 1'b1;
    step(1);
    chk_bits(latched, 16'h0001);
    evt_clr[0] = 1'b0;
    int_evt[0] = 1'b0;
    step(4);
    chk_lines(4'hf, 1'b1);
    for (int o = 0; o < ER_NUM_OUT; o++) begin
      chk_bits(status[o], 16'h0001);
    end
    chk_bits(latched, 16'h0001);
    chk_bits({15'h0000, clk_run}, 16'h0001);
    evt_clr[0] = 1'b1;
    step(1);
    evt_clr[0] = 1'b0;
    step(4);
    chk_lines(4'h0, 1'b0);
    chk_bits(latched, 16'h0000);
    cfg.latch_mode[0] = 1'b0;
    $display("test latch done");
  endtask

  // pad 0 as direct, low-active source; idles high from reset on,
  // since flipping pad and polarity one by one would glitch an event
  task automatic t_pad();
    gpio_pad[0] = 1'b0;
    step(4);
    chk_lines(4'hf, 1'b1);
    chk_bits(status[1], 16'h0100);
    gpio_pad[0] = 1'b1;
    step(4);
    chk_lines(4'h0, 1'b0);
    chk_bits(latched, 16'h0000);
    $display("test pad done");
  endtask

  // per-output mask, then global mask, on direct input 0
  task automatic t_mask();
    cfg.out_mask[1][0] = 1'b1;
    int_evt[0] = 1'b1;
    step(4);
    chk_lines(4'b1101, 1'b1);
    chk_bits(status[1], 16'h0000);
    chk_bits(status[3], 16'h0001);
    cfg.global_mask[0] = 1'b1;
    step(4);
    chk_lines(4'h0, 1'b0);
    int_evt[0] = 1'b0;
    $display("test mask done");
  endtask

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial begin
    rst_n = 1'b0;
    int_evt = '0;
    // pad 0 idles high and is low-active, so it starts inactive
    gpio_pad = 8'h01;
    cfg = '0;
    cfg.pol_high = '1;
    cfg.pol_high[ER_PIN_LSB] = 1'b0;
    evt_clr = '0;
    cgu_on = 1'b1;
    bad_count = 0;
    comparisons = 0;
    repeat (20) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    step(3);
    chk_lines(4'h0, 1'b0);
    t_latch();
    t_pad();
    t_mask();
    give_verdict();
  end

  // tests need about 50 cycles; allow far more
  initial begin
    #(ER_CLK_NS * 2000);
    bad_count++;
    give_verdict();
  end
endmodule // er_router_tb_top
`default_nettype wire
